// >>> hw/charge_setpoint_map.svh
`ifndef CHARGE_SETPOINT_MAP_SVH
`define CHARGE_SETPOINT_MAP_SVH

// Byte offsets of the setpoint registers
`define ADDR_CUR_LO 8'h02
`define ADDR_CUR_HI 8'h03
`define ADDR_VOLT_LO 8'h04
`define ADDR_VOLT_HI 8'h05

// Field positions
`define CUR_LO_MSB 7
`define CUR_LO_LSB 6
`define CUR_HI_MSB 4
`define VOLT_LO_MSB 7
`define VOLT_LO_LSB 3
`define VOLT_HI_MSB 6
`define VOLT_HI_RSVD 7

// Reset values
`define CUR_RESET 7'h02
`define CUR_LO_RESET 8'h80
`define CELLS_RESET 3'h1

// Voltage field limits in 8 mV steps: 1024 mV and 23000 mV
`define VOLT_MIN 12'h080
`define VOLT_MAX 12'hb3b

// Default voltage field per cell count: 4200, 8400, 12600, 16800, 21000 mV
`define VOLT_DEF_1S 12'h20d
`define VOLT_DEF_2S 12'h41a
`define VOLT_DEF_3S 12'h627
`define VOLT_DEF_4S 12'h834
`define VOLT_DEF_5S 12'ha41

// Low-battery clamp figures in mA and mV
`define CLAMP_LOW_MA 16'h0180
`define CLAMP_MID_MA 16'h07d0
`define CLAMP_NONE_MA 16'hffff
`define ONE_CELL_LOW_MV 16'h0bb8

`endif

// >>> hw/charge_setpoint_pkg.sv
package charge_setpoint_pkg;

    typedef enum logic [1:0] {
        ST_SYNC_A,
        ST_SYNC_B,
        ST_LOAD,
        ST_RUN
    } init_state_t;

endpackage

// >>> hw/charge_setpoint_registers.sv
// Operation
// - Current low byte bit 7 adds 256 mA and bit 6 adds 128 mA; bit 7 resets to one, bit 6 to zero.
// - Written values in current low byte bits 5-0 and voltage low byte bits 2-0 are ignored and read zero.
// - For two to five cells the current is clamped to 384 mA while the battery is below min system voltage.
// - For one cell the current is clamped to 384 mA below 3 V and 2 A up to min system voltage.
// - The voltage setting spans 1.024 V to 23.000 V in 8 mV steps.
// - A nonzero voltage write outside 1.024 V to 23.000 V is discarded and the old setting kept.
// - After power-on the voltage loads a default picked by the cell count pin.
// - With charger ok high, writing a nonzero current value starts charging, using the held voltage.
// - Writing zero voltage keeps the voltage and forces the current to zero, stopping charge.
// - The 12-bit voltage field spans high byte bits 6-0 and low byte bits 7-3, 8 mV to 16384 mV.
// - Voltage high byte bit 7 is reserved, resets zero, and a write with it set is invalid.
// - Current high byte bits 4-0 carry current bits 6-2, weights 8192 mA to 512 mA.
`timescale 1ns/100ps
`include "charge_setpoint_map.svh"
module charge_setpoint_registers
    import charge_setpoint_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_charger_ok_status,
    input wire logic [2:0] i_cell_count_pin,
    input wire logic [15:0] i_battery_mv,
    input wire logic [15:0] i_min_system_voltage_mv,
    output logic [7:0] o_rd_data,
    output logic o_charge_enable,
    output logic [15:0] o_charge_current_ma,
    output logic [15:0] o_charge_voltage_mv
);
    typedef struct packed {
        init_state_t st;
        logic ok_s1;
        logic ok_s2;
        logic [2:0] cell_s1;
        logic [2:0] cell_s2;
        logic [15:0] bat_s1;
        logic [15:0] bat_s2;
        logic [15:0] vsys_s1;
        logic [15:0] vsys_s2;
        logic [2:0] cells;
        logic [6:0] cur;
        logic [7:0] cur_lo_pend;
        logic [11:0] volt;
        logic [7:0] volt_lo_pend;
        logic chg_en;
        logic [7:0] rd;
        logic [15:0] cur_out;
        logic [15:0] volt_out;
    } regs_t;

    localparam regs_t RESET_STATE = '{
        st: ST_SYNC_A,
        cells: `CELLS_RESET,
        cur: `CUR_RESET,
        cur_lo_pend: `CUR_LO_RESET,
        volt: `VOLT_DEF_1S,
        default: '0
    };

    regs_t state_reg;
    regs_t state_next;
    clamp_if u_clamp_if();

    function automatic logic volt_in_range(input logic [11:0] v);
        return (v >= `VOLT_MIN) && (v <= `VOLT_MAX);
    endfunction

    function automatic logic [11:0] default_volt(input logic [2:0] cells);
        case (cells)
            3'h2: default_volt = `VOLT_DEF_2S;
            3'h3: default_volt = `VOLT_DEF_3S;
            3'h4: default_volt = `VOLT_DEF_4S;
            3'h5: default_volt = `VOLT_DEF_5S;
            default: default_volt = `VOLT_DEF_1S;
        endcase
    endfunction

    // Reserved bits read as zero because read_byte fills them with constant zeros
    function automatic logic [7:0] read_byte(input logic [7:0] addr, input logic [6:0] cur,
                                             input logic [11:0] volt);
        case (addr)
            `ADDR_CUR_LO: read_byte = {cur[1:0], 6'h00};
            `ADDR_CUR_HI: read_byte = {3'h0, cur[6:2]};
            `ADDR_VOLT_LO: read_byte = {volt[4:0], 3'h0};
            `ADDR_VOLT_HI: read_byte = {1'b0, volt[11:5]};
            default: read_byte = 8'h00;
        endcase
    endfunction

    logic [6:0] cur_wr;
    logic [11:0] volt_wr;
    logic wr_run;

    assign cur_wr = {i_wr_data[`CUR_HI_MSB:0], state_reg.cur_lo_pend[`CUR_LO_MSB:`CUR_LO_LSB]};
    assign volt_wr = {i_wr_data[`VOLT_HI_MSB:0],
                      state_reg.volt_lo_pend[`VOLT_LO_MSB:`VOLT_LO_LSB]};
    assign wr_run = i_wr_en && (state_reg.st == ST_RUN);

    assign u_clamp_if.cells = state_reg.cells;
    assign u_clamp_if.bat_mv = state_reg.bat_s2;
    assign u_clamp_if.vsys_mv = state_reg.vsys_s2;
    assign u_clamp_if.req_ma = {2'b00, state_reg.cur, 7'h00};

    current_clamp u_current_clamp (
        .c(u_clamp_if.clamp)
    );

    always_comb begin
        state_next = state_reg;
        state_next.ok_s1 = i_charger_ok_status;
        state_next.ok_s2 = state_reg.ok_s1;
        state_next.cell_s1 = i_cell_count_pin;
        state_next.cell_s2 = state_reg.cell_s1;
        state_next.bat_s1 = i_battery_mv;
        state_next.bat_s2 = state_reg.bat_s1;
        state_next.vsys_s1 = i_min_system_voltage_mv;
        state_next.vsys_s2 = state_reg.vsys_s1;
        if (i_rd_en) begin
            state_next.rd = read_byte(i_addr, state_reg.cur, state_reg.volt);
        end
        // Strap is read only after it has crossed the synchroniser
        case (state_reg.st)
            ST_SYNC_A: state_next.st = ST_SYNC_B;
            ST_SYNC_B: state_next.st = ST_LOAD;
            ST_LOAD: begin
                // Unused strap codes fall back to one cell, matching the default voltage
                state_next.cells = (state_reg.cell_s2 >= 3'h2 && state_reg.cell_s2 <= 3'h5)
                                   ? state_reg.cell_s2 : 3'h1;
                state_next.volt = default_volt(state_reg.cell_s2);
                state_next.st = ST_RUN;
            end
            ST_RUN: begin
                if (i_wr_en) begin
                    case (i_addr)
                        `ADDR_CUR_LO: state_next.cur_lo_pend = i_wr_data;
                        `ADDR_CUR_HI: begin
                            // Reserved high bits set mark the whole word invalid
                            if (i_wr_data[7:5] == 3'h0) begin
                                state_next.cur = cur_wr;
                                state_next.chg_en = state_reg.ok_s2 && (cur_wr != 7'h00);
                            end
                        end
                        `ADDR_VOLT_LO: state_next.volt_lo_pend = i_wr_data;
                        `ADDR_VOLT_HI: begin
                            if (i_wr_data[`VOLT_HI_RSVD]) begin
                                state_next.volt = state_reg.volt;
                            end else if (volt_wr == 12'h000) begin
                                state_next.cur = 7'h00;
                                state_next.chg_en = 1'b0;
                            end else if (volt_in_range(volt_wr)) begin
                                state_next.volt = volt_wr;
                            end
                        end
                        default: state_next.st = ST_RUN;
                    endcase
                end
            end
            default: state_next.st = ST_SYNC_A;
        endcase
        if (!state_reg.ok_s2) begin
            state_next.chg_en = 1'b0;
        end
        state_next.cur_out = u_clamp_if.lim_ma;
        state_next.volt_out = {1'b0, state_reg.volt, 3'h0};
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            state_reg <= RESET_STATE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_rd_data = state_reg.rd;
    assign o_charge_enable = state_reg.chg_en;
    assign o_charge_current_ma = state_reg.cur_out;
    assign o_charge_voltage_mv = state_reg.volt_out;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    property p_cur_reset;
        $rose(i_resetn) |-> state_reg.cur == `CUR_RESET;
    endproperty
    a_cur_reset: assert property (p_cur_reset) else $error("current reset value wrong");

    property p_rsvd_read;
        i_rd_en && (i_addr == `ADDR_CUR_LO || i_addr == `ADDR_VOLT_LO)
            |=> o_rd_data[2:0] == 3'h0;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits read nonzero");

    property p_clamp_multi;
        state_reg.cells > 3'h1 && state_reg.bat_s2 < state_reg.vsys_s2
            |=> o_charge_current_ma <= `CLAMP_LOW_MA;
    endproperty
    a_clamp_multi: assert property (p_clamp_multi) else $error("multi-cell clamp missed");

    property p_clamp_one;
        state_reg.cells == 3'h1 && state_reg.bat_s2 >= `ONE_CELL_LOW_MV
            && state_reg.bat_s2 <= state_reg.vsys_s2 |=> o_charge_current_ma <= `CLAMP_MID_MA;
    endproperty
    a_clamp_one: assert property (p_clamp_one) else $error("one-cell clamp missed");

    property p_volt_range;
        state_reg.st == ST_RUN |-> volt_in_range(state_reg.volt);
    endproperty
    a_volt_range: assert property (p_volt_range) else $error("voltage out of range");

    property p_bad_volt;
        wr_run && i_addr == `ADDR_VOLT_HI && (i_wr_data[`VOLT_HI_RSVD]
            || (volt_wr != 12'h000 && !volt_in_range(volt_wr))) |=> $stable(state_reg.volt);
    endproperty
    a_bad_volt: assert property (p_bad_volt) else $error("invalid voltage accepted");

    property p_default;
        state_reg.st == ST_LOAD |=> state_reg.volt == default_volt($past(state_reg.cell_s2));
    endproperty
    a_default: assert property (p_default) else $error("default voltage wrong");

    property p_start;
        wr_run && i_addr == `ADDR_CUR_HI && i_wr_data[7:5] == 3'h0 && cur_wr != 7'h00
            && state_reg.ok_s2 |=> o_charge_enable ##1 o_charge_current_ma != 16'h0000;
    endproperty
    a_start: assert property (p_start) else $error("charge did not start");

    property p_zero_volt;
        wr_run && i_addr == `ADDR_VOLT_HI && i_wr_data == 8'h00
            && state_reg.volt_lo_pend[7:3] == 5'h00
            |=> state_reg.cur == 7'h00 && !o_charge_enable && $stable(state_reg.volt);
    endproperty
    a_zero_volt: assert property (p_zero_volt) else $error("zero voltage write wrong");

    property p_volt_out;
        state_reg.st == ST_RUN |=> o_charge_voltage_mv == {1'b0, $past(state_reg.volt), 3'h0};
    endproperty
    a_volt_out: assert property (p_volt_out) else $error("voltage weight wrong");

    property p_cur_word;
        wr_run && i_addr == `ADDR_CUR_HI && i_wr_data[7:5] == 3'h0
            |=> state_reg.cur == $past(cur_wr);
    endproperty
    a_cur_word: assert property (p_cur_word) else $error("current word assembly wrong");

    property p_low_only;
        wr_run && (i_addr == `ADDR_VOLT_LO || i_addr == `ADDR_CUR_LO)
            |=> $stable(state_reg.volt) && $stable(state_reg.cur);
    endproperty
    a_low_only: assert property (p_low_only) else $error("low byte alone took effect");
endmodule // charge_setpoint_registers

// >>> hw/clamp_if.sv
`timescale 1ns/100ps
interface clamp_if;
    logic [2:0] cells;
    logic [15:0] bat_mv;
    logic [15:0] vsys_mv;
    logic [15:0] req_ma;
    logic [15:0] lim_ma;

    modport requester (output cells, output bat_mv, output vsys_mv, output req_ma,
                       input lim_ma);
    modport clamp (input cells, input bat_mv, input vsys_mv, input req_ma,
                   output lim_ma);
endinterface

// >>> hw/current_clamp.sv
`timescale 1ns/100ps
`include "charge_setpoint_map.svh"
module current_clamp (
    clamp_if.clamp c
);
    logic [15:0] limit;

    always_comb begin
        limit = `CLAMP_NONE_MA;
        if (c.cells == 3'h1) begin
            if (c.bat_mv < `ONE_CELL_LOW_MV) begin
                limit = `CLAMP_LOW_MA;
            end else if (c.bat_mv <= c.vsys_mv) begin
                limit = `CLAMP_MID_MA;
            end
        end else if (c.bat_mv < c.vsys_mv) begin
            limit = `CLAMP_LOW_MA;
        end
        c.lim_ma = (c.req_ma < limit) ? c.req_ma : limit;
    end
endmodule // current_clamp

// >>> sim/charge_setpoint_registers_tb_top.sv
`timescale 1ns/100ps
`define CHECK_EQ(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
    $display("wrong value at %0t ns: %s", $time, msg); end end
module charge_setpoint_registers_tb_top;
    typedef struct {logic [7:0] hi; logic [7:0] lo; logic [15:0] exp_mv;} volt_row_t;
    logic i_ref_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic ok = 1'b0;
    logic [2:0] cells = 3'h1;
    logic [15:0] bat = 16'h0fa0;
    logic [15:0] vsys = 16'h0e10;
    logic wr_en, rd_en, en;
    logic [7:0] addr, wr_data, rd_data, rd_val;
    logic [15:0] cur_ma, volt_mv, field;
    int bad_count = 0;
    int comparisons = 0;
    // Boundary and refused voltage writes; refused rows keep the last accepted value
    volt_row_t rows[7] = '{'{8'h41, 8'ha0, 16'h41a0}, '{8'h04, 8'h00, 16'h0400},
        '{8'h59, 8'hd8, 16'h59d8}, '{8'h03, 8'hf8, 16'h59d8}, '{8'h59, 8'he0, 16'h59d8},
        '{8'h84, 8'h00, 16'h59d8}, '{8'h04, 8'h07, 16'h0400}};

    always #25 i_ref_clk = ~i_ref_clk;

    charge_setpoint_registers i_charge_setpoint_registers (.i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr),
        .i_wr_data(wr_data), .i_charger_ok_status(ok), .i_cell_count_pin(cells),
        .i_battery_mv(bat), .i_min_system_voltage_mv(vsys), .o_rd_data(rd_data),
        .o_charge_enable(en), .o_charge_current_ma(cur_ma), .o_charge_voltage_mv(volt_mv));

    host_port_model i_host_port_model (.i_ref_clk(i_ref_clk), .i_rd_data(rd_data),
        .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wr_data(wr_data));

    task automatic report_and_stop();
        if (bad_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic do_reset(input logic [2:0] n);
        @(posedge i_ref_clk);
        cells <= n;
        i_resetn <= 1'b0;
        repeat (10) @(posedge i_ref_clk);
        `CHECK_EQ(volt_mv, 16'h0000, "voltage in reset")
        i_resetn <= 1'b1;
        repeat (6) @(posedge i_ref_clk);
    endtask

    task automatic settle();
        repeat (5) @(posedge i_ref_clk);
    endtask

    task automatic check_read(input logic [7:0] a, input logic [7:0] exp);
        i_host_port_model.read(a, rd_val);
        `CHECK_EQ(rd_val, exp, "read back")
    endtask

    initial begin
        for (int n = 1; n <= 5; n++) begin
            do_reset(3'(n));
            `CHECK_EQ(volt_mv, 16'(n * 4200), "default voltage")
            `CHECK_EQ(cur_ma, 16'h0100, "default current")
        end
        do_reset(3'h7);
        `CHECK_EQ(volt_mv, 16'h1068, "odd strap default")
        do_reset(3'h1);
        check_read(8'h02, 8'h80);
        check_read(8'h05, 8'h10);
        check_read(8'h04, 8'h68);
        check_read(8'h07, 8'h00);
        foreach (rows[i]) begin
            i_host_port_model.write_pair(8'h04, rows[i].lo, rows[i].hi);
            settle();
            field = rows[i].exp_mv >> 3;
            `CHECK_EQ(volt_mv, rows[i].exp_mv, "voltage write")
            check_read(8'h05, {1'b0, field[11:5]});
            check_read(8'h04, {field[4:0], 3'h0});
        end
        // Voltage goes in before current so charging never starts at the 1024 mV left by the last row
        i_host_port_model.write_pair(8'h04, 8'ha0, 8'h41);
        @(posedge i_ref_clk);
        ok <= 1'b1;
        settle();
        i_host_port_model.write_pair(8'h02, 8'hff, 8'h1f);
        settle();
        `CHECK_EQ(en, 1'b1, "charge start")
        `CHECK_EQ(cur_ma, 16'h3f80, "full current")
        check_read(8'h02, 8'hc0);
        i_host_port_model.access(1'b1, 8'h02, 8'h40);
        settle();
        check_read(8'h02, 8'hc0);
        i_host_port_model.access(1'b1, 8'h03, 8'he0);
        settle();
        `CHECK_EQ(cur_ma, 16'h3f80, "current reserved write")
        @(posedge i_ref_clk);
        bat <= 16'h07d0;
        settle();
        `CHECK_EQ(cur_ma, 16'h0180, "one cell low clamp")
        @(posedge i_ref_clk);
        bat <= 16'h0ce4;
        settle();
        `CHECK_EQ(cur_ma, 16'h07d0, "one cell mid clamp")
        // The strap is taken only at power-on, so a new cell count needs a reset
        do_reset(3'h3);
        i_host_port_model.write_pair(8'h02, 8'hff, 8'h1f);
        settle();
        `CHECK_EQ(cur_ma, 16'h0180, "multi cell clamp")
        @(posedge i_ref_clk);
        bat <= 16'h0fa0;
        settle();
        `CHECK_EQ(cur_ma, 16'h3f80, "clamp removed")
        i_host_port_model.write_pair(8'h04, 8'h00, 8'h00);
        settle();
        `CHECK_EQ(volt_mv, 16'h3138, "zero write voltage")
        `CHECK_EQ(cur_ma, 16'h0000, "zero write current")
        `CHECK_EQ(en, 1'b0, "zero write stop")
        check_read(8'h02, 8'h00);
        i_host_port_model.write_pair(8'h02, 8'h80, 8'h00);
        settle();
        `CHECK_EQ(en, 1'b1, "charge restart")
        @(posedge i_ref_clk);
        ok <= 1'b0;
        settle();
        `CHECK_EQ(en, 1'b0, "charger ok drop")
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge i_ref_clk);
        bad_count++;
        report_and_stop();
    end
endmodule // charge_setpoint_registers_tb_top

// >>> sim/host_port_model.sv
`timescale 1ns/100ps
module host_port_model (
    input wire logic i_ref_clk,
    input wire logic [7:0] i_rd_data,
    output logic o_wr_en,
    output logic o_rd_en,
    output logic [7:0] o_addr,
    output logic [7:0] o_wr_data
);
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = 8'h00;
        o_wr_data = 8'h00;
    end

    // Address and data are inverted once released, so a stale byte is never mistaken for live
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_ref_clk);
        o_wr_en <= wr;
        o_rd_en <= ~wr;
        o_addr <= addr;
        o_wr_data <= data;
        @(posedge i_ref_clk);
        o_wr_en <= 1'b0;
        o_rd_en <= 1'b0;
        o_addr <= ~addr;
        o_wr_data <= ~data;
    endtask

    task automatic write_pair(input logic [7:0] lo_addr, input logic [7:0] lo, input logic [7:0] hi);
        access(1'b1, lo_addr, lo);
        access(1'b1, lo_addr + 8'h01, hi);
    endtask

    task automatic read(input logic [7:0] addr, output logic [7:0] data);
        access(1'b0, addr, 8'h00);
        @(posedge i_ref_clk);
        #1 data = i_rd_data;
    endtask
endmodule // host_port_model
